/* src/bdio_top.sv */
`timescale 1ns/1ps

module bdio_top
  import bdio_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] di_pin,
  input  wire logic        ack_button,
  input  wire logic        internal_ok,
  input  wire logic        sys_a_fault,
  input  wire logic        sys_b_fault,
  output logic             breaker_a_open,
  output logic             breaker_b_open,
  output logic             breaker_a_unload,
  output logic             breaker_a_close_en,
  output logic             breaker_b_unload,
  output logic             breaker_b_close_en,
  output logic             relay_ready,
  output logic             relay_horn,
  output logic             relay_sys_b,
  output logic             relay_sys_a,
  output logic             irq
);

  bdio_state_t r;
  bdio_state_t n;
  logic [11:0] fixed;
  logic [11:0] alarm_act;
  logic [11:0] new_set;
  logic        ext_ack;
  logic        ack_ev;
  logic        sw_ack;
  logic        new_hi;
  logic        central;
  logic        hit;
  logic        wr_acc;
  logic [31:0] rdata;
  logic [3:0]  ev;
  logic [3:0]  clr;

  // ------------------------------------------------------------
  // Control term selection from a discrete input
  // ------------------------------------------------------------
  function automatic logic pick(input logic [11:0]      di,
                                input logic [11:0]      fx,
                                input logic [SRC_W-1:0] idx);
    logic v;
    v = 1'b0;
    if (idx < SRC_W'(NUM_DI))
      v = di[idx] & ~fx[idx];
    return v;
  endfunction : pick

  // ------------------------------------------------------------
  // Per-input alarm qualification
  // ------------------------------------------------------------
  // Fixed inputs follow the application mode only
  assign fixed = FIX_A_MASK | (r.dual ? FIX_B_MASK : 12'h000);

  for (genvar i = 0; i < NUM_DI; i++)
  begin : g_alarm
    // Alarm inputs evaluated in every operating state
    assign alarm_act[i] = r.di_s2[i] & r.alarm_en[i] & ~fixed[i];
    assign new_set[i]   = alarm_act[i] & ~r.latch[i];
  end

  // ------------------------------------------------------------
  // Register read decode
  // ------------------------------------------------------------
  always_comb
  begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    case (paddr)
      OFS_CTRL:    rdata[CTRL_DUAL] = r.dual;
      OFS_DI:      rdata[11:0] = r.di_s2;
      OFS_ALM_EN:  rdata[11:0] = r.alarm_en;
      OFS_ALM_CLS: rdata[11:0] = r.alarm_cls;
      OFS_SRC:     rdata[19:0] = r.ctrl_src;
      OFS_ALM:
      begin
        rdata[11:0]       = r.latch;
        rdata[ALM_HORN]   = r.horn;
        rdata[ALM_FIRST]  = r.ack_first;
        rdata[ALM_A_OPEN] = r.a_open;
        rdata[ALM_B_OPEN] = r.b_open;
      end
      OFS_REL:     rdata[8:0] = r.rel_cfg;
      OFS_ISTAT:   rdata[3:0] = r.istat;
      OFS_IMASK:   rdata[3:0] = r.imask;
      default:     hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    n        = r;
    n.di_s1  = di_pin;
    n.di_s2  = r.di_s1;
    n.btn_s1 = ack_button;
    n.btn_s2 = r.btn_s1;
    n.rd_stat = 1'b0;
    wr_acc   = 1'b0;
    sw_ack   = 1'b0;
    clr      = 4'h0;

    // APB: setup captures read data, access answers
    case (r.st)
      ST_IDLE:
      begin
        if (psel && !penable)
        begin
          n.st      = ST_ACC;
          n.prdata  = pwrite ? 32'h0000_0000 : rdata;
          n.pslverr = ~hit;
          n.rd_stat = ~pwrite && (paddr == OFS_ISTAT);
        end
      end
      ST_ACC:
      begin
        n.st      = ST_IDLE;
        n.pslverr = 1'b0;
        wr_acc    = pwrite && !r.pslverr;
        if (r.rd_stat)
          clr = r.prdata[3:0];
      end
      default:
      begin
        n.st      = ST_IDLE;
        n.pslverr = 1'b0;
      end
    endcase

    if (wr_acc)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          n.dual = pwdata[CTRL_DUAL];
          sw_ack = pwdata[CTRL_ACK];
        end
        OFS_ALM_EN:  n.alarm_en  = pwdata[11:0];
        OFS_ALM_CLS: n.alarm_cls = pwdata[11:0];
        OFS_SRC:     n.ctrl_src  = pwdata[19:0];
        OFS_REL:     n.rel_cfg   = pwdata[8:0];
        OFS_IMASK:   n.imask     = pwdata[3:0];
        default:     n.imask     = r.imask;
      endcase
    end

    // Breaker replies: energized input means breaker open; B reply counts in dual mode only
    n.a_open = r.di_s2[DI_A_REPLY];
    n.b_open = r.dual & r.di_s2[DI_B_REPLY];

    // Control terms, defaults on inputs five and six for A, two and three for B
    n.a_unload   = pick(r.di_s2, fixed, r.ctrl_src[SRC_A_OPEN +: SRC_W]);
    n.a_close_en = pick(r.di_s2, fixed, r.ctrl_src[SRC_A_CLOSE +: SRC_W]);
    n.b_unload   = pick(r.di_s2, fixed, r.ctrl_src[SRC_B_OPEN +: SRC_W]);
    n.b_close_en = pick(r.di_s2, fixed, r.ctrl_src[SRC_B_CLOSE +: SRC_W]);

    // Acknowledge from external input, front button or software
    ext_ack     = pick(r.di_s2, fixed, r.ctrl_src[SRC_ACK +: SRC_W]);
    n.ext_ack_d = ext_ack;
    n.btn_d     = r.btn_s2;
    ack_ev      = (ext_ack & ~r.ext_ack_d) | (r.btn_s2 & ~r.btn_d) | sw_ack;

    n.latch = r.latch | alarm_act;
    if (ack_ev)
    begin
      if (!r.ack_first)
      begin
        n.horn      = 1'b0;
        n.ack_first = 1'b1;
      end
      else
      begin
        n.latch     = r.latch & alarm_act;
        n.ack_first = 1'b0;
      end
    end

    // Only class B or higher arm the horn; new alarm wins over ack
    new_hi = |(new_set & r.alarm_cls);
    if (new_hi)
    begin
      n.horn      = 1'b1;
      n.ack_first = 1'b0;
    end
    central = |(n.latch & r.alarm_cls);

    // Relay one opens when its logic term becomes true
    n.relay_ready = ~(~internal_ok | r.rel_cfg[REL_R1_SW] |
                      (r.rel_cfg[REL_R1_ALM] & central));
    n.relay_horn  = r.rel_cfg[REL_OVR] ? r.rel_cfg[REL_VAL]
                                       : n.horn;
    n.relay_sys_b = r.rel_cfg[REL_OVR+1] ? r.rel_cfg[REL_VAL+1]
                                         : sys_b_fault;
    n.relay_sys_a = r.rel_cfg[REL_OVR+2] ? r.rel_cfg[REL_VAL+2]
                                         : sys_a_fault;

    // Sticky events, cleared by a read; a new event wins
    ev            = 4'h0;
    ev[IRQ_NEW]   = new_hi;
    ev[IRQ_ACK]   = ack_ev;
    ev[IRQ_A_CHG] = n.a_open ^ r.a_open;
    ev[IRQ_B_CHG] = n.b_open ^ r.b_open;
    n.istat       = (r.istat & ~clr) | ev;
    n.irq         = |(n.istat & n.imask);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r           <= '0;
      r.st        <= ST_IDLE;
      r.alarm_en  <= RST_ALM_EN;
      r.alarm_cls <= RST_ALM_CLS;
      r.ctrl_src  <= RST_SRC;
    end
    else
      r <= n;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata             = r.prdata;
  assign pready             = r.st[ST_ACC_BIT];
  assign pslverr            = r.pslverr;
  assign breaker_a_open     = r.a_open;
  assign breaker_b_open     = r.b_open;
  assign breaker_a_unload   = r.a_unload;
  assign breaker_a_close_en = r.a_close_en;
  assign breaker_b_unload   = r.b_unload;
  assign breaker_b_close_en = r.b_close_en;
  assign relay_ready        = r.relay_ready;
  assign relay_horn         = r.relay_horn;
  assign relay_sys_b        = r.relay_sys_b;
  assign relay_sys_a        = r.relay_sys_a;
  assign irq                = r.irq;

endmodule : bdio_top

/* src/bdio_pkg.sv */
package bdio_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int          NUM_DI      = 12;
  localparam int          SRC_W       = 4;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [31:0] OFS_CTRL    = 32'h0000_0000;
  localparam logic [31:0] OFS_DI      = 32'h0000_0004;
  localparam logic [31:0] OFS_ALM_EN  = 32'h0000_0008;
  localparam logic [31:0] OFS_ALM_CLS = 32'h0000_000C;
  localparam logic [31:0] OFS_SRC     = 32'h0000_0010;
  localparam logic [31:0] OFS_ALM     = 32'h0000_0014;
  localparam logic [31:0] OFS_REL     = 32'h0000_0018;
  localparam logic [31:0] OFS_ISTAT   = 32'h0000_001C;
  localparam logic [31:0] OFS_IMASK   = 32'h0000_0020;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          CTRL_DUAL   = 0;
  localparam int          CTRL_ACK    = 1;
  localparam int          SRC_A_OPEN  = 0;
  localparam int          SRC_A_CLOSE = 4;
  localparam int          SRC_B_OPEN  = 8;
  localparam int          SRC_B_CLOSE = 12;
  localparam int          SRC_ACK     = 16;
  localparam int          REL_R1_SW   = 0;
  localparam int          REL_OVR     = 1;
  localparam int          REL_VAL     = 5;
  localparam int          REL_R1_ALM  = 8;
  localparam int          ALM_HORN    = 16;
  localparam int          ALM_FIRST   = 17;
  localparam int          ALM_A_OPEN  = 18;
  localparam int          ALM_B_OPEN  = 19;
  localparam int          IRQ_NEW     = 0;
  localparam int          IRQ_ACK     = 1;
  localparam int          IRQ_A_CHG   = 2;
  localparam int          IRQ_B_CHG   = 3;
  localparam int          DI_A_REPLY  = 7;
  localparam int          DI_B_REPLY  = 4;

  // ------------------------------------------------------------
  // Reset values and fixed input masks
  // ------------------------------------------------------------
  localparam logic [11:0] RST_ALM_EN  = 12'hF00;
  localparam logic [11:0] RST_ALM_CLS = 12'hF00;
  localparam logic [19:0] RST_SRC     = 20'h13265;
  localparam logic [11:0] FIX_A_MASK  = 12'h080;
  localparam logic [11:0] FIX_B_MASK  = 12'h010;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } bdio_st_t;

  localparam int          ST_ACC_BIT  = 1;

  typedef struct packed {
    bdio_st_t    st;
    logic [31:0] prdata;
    logic        pslverr;
    logic        rd_stat;
    logic [11:0] di_s1;
    logic [11:0] di_s2;
    logic        btn_s1;
    logic        btn_s2;
    logic        ext_ack_d;
    logic        btn_d;
    logic        dual;
    logic [11:0] alarm_en;
    logic [11:0] alarm_cls;
    logic [19:0] ctrl_src;
    logic [8:0]  rel_cfg;
    logic [11:0] latch;
    logic        horn;
    logic        ack_first;
    logic [3:0]  istat;
    logic [3:0]  imask;
    logic        irq;
    logic        a_open;
    logic        b_open;
    logic        a_unload;
    logic        a_close_en;
    logic        b_unload;
    logic        b_close_en;
    logic        relay_ready;
    logic        relay_horn;
    logic        relay_sys_b;
    logic        relay_sys_a;
  } bdio_state_t;

endpackage : bdio_pkg

/* verification/bdio_props.sv */
`timescale 1ns/1ps
module bdio_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] di_pin,
  input wire logic        ack_button,
  input wire logic        internal_ok,
  input wire logic        sys_a_fault,
  input wire logic        breaker_a_open,
  input wire logic        breaker_b_open,
  input wire logic        relay_ready,
  input wire logic        relay_horn,
  input wire logic        relay_sys_a
);
  logic [2:0] up;

  // Edges since reset release, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up <= 3'h0;
    else if (up != 3'h4)
      up <= up + 3'h1;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ack;
    up == 3'h4 && $rose(ack_button) && $stable(di_pin);
  endsequence
  sequence s_quiet;
    ##[3:6] !relay_horn;
  endsequence

  AST_PREADY: assert property (psel && !penable |=> pready) else $error("setup not answered");
  AST_PREADY_ONE: assert property (pready |=> !pready) else $error("pready held too long");
  AST_UNMAPPED: assert property (psel && !penable && paddr > 32'h20 |=> pslverr)
    else $error("unmapped access not refused");
  AST_A_REPLY: assert property (up == 3'h4 |-> breaker_a_open == $past(di_pin[7], 3))
    else $error("breaker_a reply wrong");
  AST_B_REPLY: assert property (up == 3'h4 && !$past(di_pin[4], 3) |-> !breaker_b_open)
    else $error("breaker_b reply wrong");
  AST_READY: assert property (!internal_ok |=> !relay_ready)
    else $error("ready relay not opened");
  AST_SYS_A: assert property (up != 3'h0 |-> relay_sys_a == $past(sys_a_fault))
    else $error("system relay wrong");
  AST_HORN_ACK: assert property (s_ack |-> s_quiet)
    else $error("horn not silenced");
endmodule : bdio_props

bind bdio_top bdio_props bdio_props_inst (.*);

/* verification/bdio_plant.sv */
`timescale 1ns/1ps
module bdio_plant
(
  input  wire logic       a_open,
  input  wire logic       b_open,
  input  wire logic [1:0] ctrl,
  input  wire logic [3:0] alarms,
  input  wire logic       ext_ack,
  input  wire logic       push,
  output logic [11:0]     di_pin,
  output logic            ack_button
);
  // Normally-closed auxiliary contacts energize while a breaker is open
  assign di_pin = {alarms, a_open, ctrl, b_open, 2'h0, ext_ack, 1'h0};
  assign ack_button = push;
endmodule : bdio_plant

/* verification/bdio_top_tb.sv */
`timescale 1ns/1ps
module bdio_top_tb;
  import bdio_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, push, ext_ack;
  logic        internal_ok, sys_a_fault, sys_b_fault, a_open, b_open, ack_button;
  logic        relay_ready, relay_horn, relay_sys_a, relay_sys_b, breaker_a_open, breaker_b_open;
  logic        breaker_a_unload, breaker_a_close_en, breaker_b_unload, breaker_b_close_en;
  logic [1:0]  ctrl;
  logic [3:0]  alarms;
  logic [11:0] di_pin;
  logic [31:0] paddr, pwdata, prdata, rd;
  int          n_fail, compares;

  bdio_top bdio_top_inst (.*);
  bdio_plant bdio_plant_inst (.*);

  // ------
  // Helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask : settle

  task automatic stop_test;
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    rchk(OFS_ALM_EN, 32'h0000_0F00);
    rchk(OFS_ALM_CLS, 32'h0000_0F00);
    rchk(OFS_SRC, 32'h0001_3265);
    rchk(32'h0000_0040, 32'h0000_0000);
    chk({31'h0, er}, 32'h1);
  endtask : t_regs

  task automatic t_reply;
    a_open <= 1'b1;
    b_open <= 1'b1;
    settle;
    chk({30'h0, breaker_a_open, breaker_b_open}, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h1);
    settle;
    chk({30'h0, breaker_a_open, breaker_b_open}, 32'h3);
    a_open <= 1'b0;
    settle;
    chk({30'h0, breaker_a_open, breaker_b_open}, 32'h1);
    rchk(OFS_DI, 32'h0000_0010);
  endtask : t_reply

  task automatic t_ctrl;
    ctrl <= 2'b01;
    settle;
    chk({30'h0, breaker_a_unload, breaker_a_close_en}, 32'h2);
    ctrl <= 2'b10;
    a_open <= 1'b1;
    // Fixed reply input chosen as a source must stay inert
    apb(1'b1, OFS_SRC, 32'h0001_6667);
    settle;
    chk({28'h0, breaker_a_unload, breaker_a_close_en, breaker_b_unload, breaker_b_close_en},
        32'h7);
    ctrl <= 2'b00;
    a_open <= 1'b0;
    settle;
  endtask : t_ctrl

  task automatic t_horn;
    rchk(OFS_ISTAT, 32'h0000_000C);
    apb(1'b1, OFS_IMASK, 32'h1);
    alarms <= 4'h1;
    settle;
    chk({30'h0, relay_horn, irq}, 32'h3);
    push <= 1'b1;
    settle;
    chk({31'h0, relay_horn}, 32'h0);
    rchk(OFS_ISTAT, 32'h0000_0003);
    push <= 1'b0;
    alarms <= 4'h3;
    settle;
    chk({30'h0, relay_horn, irq}, 32'h3);
    alarms <= 4'h0;
    ext_ack <= 1'b1;
    settle;
    ext_ack <= 1'b0;
    rchk(OFS_ALM, 32'h000A_0300);
    ext_ack <= 1'b1;
    settle;
    ext_ack <= 1'b0;
    rchk(OFS_ALM, 32'h0008_0000);
    apb(1'b1, OFS_ALM_CLS, 32'h0000_0E00);
    alarms <= 4'h1;
    settle;
    chk({31'h0, relay_horn}, 32'h0);
    apb(1'b1, OFS_IMASK, 32'h0);
    settle;
    chk({31'h0, irq}, 32'h0);
  endtask : t_horn

  task automatic t_relay;
    internal_ok <= 1'b0;
    sys_a_fault <= 1'b1;
    settle;
    chk({29'h0, relay_ready, relay_sys_a, relay_sys_b}, 32'h2);
    internal_ok <= 1'b1;
    sys_a_fault <= 1'b0;
    sys_b_fault <= 1'b1;
    settle;
    chk({29'h0, relay_ready, relay_sys_a, relay_sys_b}, 32'h5);
    apb(1'b1, OFS_REL, 32'h0000_0001);
    settle;
    chk({31'h0, relay_ready}, 32'h0);
    // Horn relay forced on by override while the horn itself is silent
    apb(1'b1, OFS_REL, 32'h0000_0022);
    settle;
    chk({30'h0, relay_ready, relay_horn}, 32'h3);
    // New class B alarm opens the ready relay when so configured
    alarms <= 4'h2;
    apb(1'b1, OFS_REL, 32'h0000_0100);
    settle;
    chk({30'h0, relay_ready, relay_horn}, 32'h1);
    // Software acknowledge silences the horn, alarm stays latched
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    settle;
    chk({30'h0, relay_ready, relay_horn}, 32'h0);
  endtask : t_relay

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sys_a_fault, sys_b_fault} = '0;
    {a_open, b_open, ctrl, alarms, ext_ack, push} = '0;
    internal_ok = 1'b1;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_reply;
    t_ctrl;
    t_horn;
    t_relay;
    stop_test;
  end

  initial
  begin
    #100us;
    n_fail++;
    stop_test;
  end
endmodule : bdio_top_tb
